// ### logic/pct_pkg.sv
// shared constants and types for the power condition timer descriptor block
package pct_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TIMER_UNIT_MS = 100;
    localparam int unsigned TICK_CYCLES = TIMER_UNIT_MS * (CLK_HZ / 1000);
    localparam int unsigned TICK_W = 22;
    localparam int unsigned NUM_COND = 3;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned MEM_AW = 5;
    localparam logic [31:0] TIMER_SAT = 32'hffff_ffff;
    // descriptor field indices within one 64-entry slot
    localparam logic [5:0] IDX_FLAGS = 6'h01;
    localparam logic [5:0] IDX_DEFAULT = 6'h04;
    localparam logic [5:0] IDX_SAVED = 6'h08;
    localparam logic [5:0] IDX_CURRENT = 6'h0c;
    localparam logic [5:0] IDX_RECOVERY = 6'h10;
    localparam logic [5:0] IDX_LOWER = 6'h14;
    localparam logic [5:0] IDX_UPPER = 6'h18;
    localparam logic [1:0] SLOT_OWN = 2'h3;
    // control registers
    localparam logic [7:0] IDX_CTRL = 8'hc0;
    localparam logic [7:0] IDX_TVAL = 8'hc1;
    localparam logic [7:0] IDX_TCMD = 8'hc2;
    localparam logic [7:0] IDX_STATUS = 8'hc3;
    localparam logic [2:0] PROG_PAGE = 3'h7;
    localparam int unsigned CTRL_EPC = 0;
    localparam int unsigned CTRL_PROG = 1;
    localparam int unsigned TCMD_EN = 4;
    localparam int unsigned TCMD_SAVE = 5;
    localparam int unsigned STAT_REJECT = 8;
    localparam logic CTRL_RST = 1'h0;
    localparam logic [31:0] TVAL_RST = 32'h0;
    // word slots in the retained memory
    localparam logic [2:0] MF_DEFAULT = 3'h0;
    localparam logic [2:0] MF_SAVED = 3'h1;
    localparam logic [2:0] MF_RECOVERY = 3'h2;
    localparam logic [2:0] MF_LOWER = 3'h3;
    localparam logic [2:0] MF_UPPER = 3'h4;
    // flags byte bit positions
    localparam int unsigned FLG_SUPPORTED = 7;
    localparam int unsigned FLG_SAVABLE = 6;
    localparam int unsigned FLG_CHANGEABLE = 5;
    localparam int unsigned FLG_DEF_EN = 4;
    localparam int unsigned FLG_SAVED_EN = 3;
    localparam int unsigned FLG_CUR_EN = 2;

    typedef struct packed {
        logic supported;
        logic savable;
        logic changeable;
        logic default_en;
    } cond_caps_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD = 3'h1,
        ST_ACK = 3'h3,
        ST_MIN = 3'h4,
        ST_MAX = 3'h6,
        ST_CHK = 3'h7
    } bus_state_t;
endpackage

// ### logic/nv_word_mem.sv
// retained word memory, no reset so contents survive every reset
`timescale 1ns/1ps
`default_nettype none
module nv_word_mem #(
    parameter int unsigned AW = 5
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    // read port
    input wire logic [AW-1:0] raddr,
    output logic [31:0] rdata_q
);
    logic [31:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end
endmodule // nv_word_mem
`default_nettype wire

// ### logic/power_condition_timer.sv
// power condition descriptors with idle timers behind an avalon-mm slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - flags bit 7 reports the condition supported, independent of epc enable.
// - savable flag shows only for supported conditions; saving needs it set.
// - changeable flag shows only for supported conditions; changes need it set.
// - default and saved timer enabled bits read zero unless supported.
// - current timer enabled bit reads zero while epc is disabled.
// - timer runs only with epc enabled, nonzero current value and enable set.
// - condition entry waits at least the current setting after command completion.
// - current setting reads zero if epc off, unsupported or not enabled.
// - timer fields in 100 ms units; counting saturates at all ones.
// - factory timer is fixed; reads valid only when supported.
// - stored timer keeps the saved value; zero means disabled.
// - wake recovery time is kept across every reset.
// - set-timer values below a nonzero lower bound are refused.
// - set-timer values above a nonzero upper bound are refused.
// - lower and upper bounds are kept across every reset.
// - three descriptors sit in consecutive 64-entry slots of the page.
module power_condition_timer import pct_pkg::*; #(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // device side
    input wire cond_caps_t [NUM_COND-1:0] cond_caps,
    input wire logic cmd_done,
    output logic [NUM_COND-1:0] enter_req
);
    bus_state_t state_q, state_d;
    logic [7:0] idx_w, addr_q;
    logic [MEM_AW-1:0] mem_raddr, mem_waddr;
    logic [31:0] mem_rdata, mem_wdata, rd_mux, tval_q, lower_q;
    logic mem_we, epc_q, prog_q, ok_q, ok_w, reject_q, tick_q, save_w, commit_w, prog_wr_w;
    logic [TICK_W-1:0] tick_cnt_q;
    cond_caps_t [NUM_COND-1:0] caps_meta_q, caps_q;
    logic [31:0] cur_q [NUM_COND];
    logic [31:0] cnt_q [NUM_COND];
    logic [31:0] cur_view [NUM_COND];
    logic [7:0] flags_w [NUM_COND];
    logic [NUM_COND-1:0] cur_en_q, saved_en_q, run_w;
    logic [1:0] cmd_cond;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);

    assign idx_w = avs_address[9:2];
    assign cmd_cond = avs_writedata[1:0];

    // descriptor field to retained word slot
    function automatic logic [MEM_AW-1:0] bus_mem_addr(input logic [7:0] idx);
        logic [2:0] f;
        f = MF_DEFAULT;
        case (idx[5:0])
            IDX_SAVED: f = MF_SAVED;
            IDX_RECOVERY: f = MF_RECOVERY;
            IDX_LOWER: f = MF_LOWER;
            IDX_UPPER: f = MF_UPPER;
            default: f = MF_DEFAULT;
        endcase
        if (idx[7:5] == PROG_PAGE) begin
            bus_mem_addr = idx[4:0];
        end else begin
            bus_mem_addr = {idx[7:6], f};
        end
    endfunction

    // capability straps, two-stage synchroniser
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            caps_meta_q <= '0;
            caps_q <= '0;
        end else begin
            caps_meta_q <= cond_caps;
            caps_q <= caps_meta_q;
        end
    end

    // bus sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (avs_read) begin
                    state_d = ST_RD;
                end else if (avs_write) begin
                    state_d = (idx_w == IDX_TCMD) ? ST_MIN : ST_ACK;
                end
            end
            ST_RD: state_d = ST_ACK;
            ST_MIN: state_d = ST_MAX;
            ST_MAX: state_d = ST_CHK;
            ST_CHK: state_d = ST_ACK;
            ST_ACK: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            avs_waitrequest <= 1'b1;
            addr_q <= 8'h0;
        end else begin
            state_q <= state_d;
            avs_waitrequest <= (state_d != ST_ACK);
            if (state_q == ST_IDLE) begin
                addr_q <= idx_w;
            end
        end
    end

    // set-timer bounds check
    always_comb begin
        ok_w = (cmd_cond != SLOT_OWN) && epc_q;
        if (ok_w) begin
            ok_w = caps_q[cmd_cond].supported && caps_q[cmd_cond].changeable;
        end
        if (lower_q != 32'h0 && tval_q < lower_q) begin
            ok_w = 1'b0;
        end
        if (mem_rdata != 32'h0 && tval_q > mem_rdata) begin
            ok_w = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lower_q <= 32'h0;
            ok_q <= 1'b0;
        end else begin
            if (state_q == ST_MAX) begin
                lower_q <= mem_rdata;
            end
            if (state_q == ST_CHK) begin
                ok_q <= ok_w;
            end
        end
    end

    assign commit_w = (state_q == ST_ACK) && avs_write && (addr_q == IDX_TCMD);
    assign save_w = commit_w && ok_q && avs_writedata[TCMD_SAVE]
        && caps_q[cmd_cond].savable;
    assign prog_wr_w = (state_q == ST_ACK) && avs_write && prog_q
        && (addr_q[7:5] == PROG_PAGE);

    // control registers, written at the acknowledging edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            epc_q <= CTRL_RST;
            prog_q <= CTRL_RST;
            tval_q <= TVAL_RST;
            reject_q <= 1'b0;
        end else if (state_q == ST_ACK && avs_write) begin
            if (addr_q == IDX_CTRL) begin
                epc_q <= avs_writedata[CTRL_EPC];
                prog_q <= avs_writedata[CTRL_PROG];
            end
            if (addr_q == IDX_TVAL) begin
                tval_q <= avs_writedata;
            end
            if (commit_w) begin
                reject_q <= !ok_q;
            end
        end
    end

    // retained words: factory, stored, recovery and bounds
    always_comb begin
        mem_raddr = '0;
        case (state_q)
            ST_IDLE: mem_raddr = bus_mem_addr(idx_w);
            ST_MIN: mem_raddr = {cmd_cond, MF_LOWER};
            ST_MAX: mem_raddr = {cmd_cond, MF_UPPER};
            default: mem_raddr = '0;
        endcase
    end

    assign mem_we = prog_wr_w || save_w;
    assign mem_waddr = prog_wr_w ? addr_q[4:0] : {cmd_cond, MF_SAVED};
    assign mem_wdata = prog_wr_w ? avs_writedata : tval_q;

    nv_word_mem #(.AW(MEM_AW)) u_mem (
        .clk(sys_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_q(mem_rdata)
    );

    // shared 100 ms tick, realigned at every completion
    always_ff @(posedge sys_clk) begin
        if (srst || cmd_done) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    genvar c;
    generate
        for (c = 0; c < NUM_COND; c++) begin : g_cond
            assign run_w[c] = epc_q && caps_q[c].supported && cur_en_q[c]
                && (cur_q[c] != 32'h0);
            assign cur_view[c] = (epc_q && caps_q[c].supported && cur_en_q[c])
                ? cur_q[c] : 32'h0;
            assign flags_w[c] = {caps_q[c].supported,
                caps_q[c].supported && caps_q[c].savable,
                caps_q[c].supported && caps_q[c].changeable,
                caps_q[c].supported && caps_q[c].default_en,
                caps_q[c].supported && saved_en_q[c],
                epc_q && cur_en_q[c],
                2'b00};

            always_ff @(posedge sys_clk) begin
                if (srst || !epc_q || !caps_q[c].supported) begin
                    cur_q[c] <= 32'h0;
                    cur_en_q[c] <= 1'b0;
                end else if (commit_w && ok_q && cmd_cond == 2'(c)) begin
                    cur_q[c] <= tval_q;
                    cur_en_q[c] <= avs_writedata[TCMD_EN];
                end
            end

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    saved_en_q[c] <= 1'b0;
                end else if (save_w && cmd_cond == 2'(c)) begin
                    saved_en_q[c] <= (tval_q != 32'h0);
                end
            end

            always_ff @(posedge sys_clk) begin
                if (srst || cmd_done || !run_w[c]) begin
                    cnt_q[c] <= 32'h0;
                    enter_req[c] <= 1'b0;
                end else begin
                    if (tick_q && cnt_q[c] != TIMER_SAT) begin
                        cnt_q[c] <= cnt_q[c] + 32'h1;
                    end
                    enter_req[c] <= (cnt_q[c] >= cur_q[c]);
                end
            end

            a_view_zero: assert property (@(posedge sys_clk) disable iff (srst)
                (!epc_q || !caps_q[c].supported || !cur_en_q[c]) |-> cur_view[c] == 32'h0)
                else $error("current setting visible while disabled");
            a_cur_zero: assert property (@(posedge sys_clk) disable iff (srst)
                !epc_q |-> ##1 !flags_w[c][FLG_CUR_EN])
                else $error("current enabled flag set with epc off");
            a_cur_clear: assert property (@(posedge sys_clk) disable iff (srst)
                !epc_q || !caps_q[c].supported |=> cur_q[c] == 32'h0 && !cur_en_q[c])
                else $error("current setting kept while epc off or unsupported");
            a_wait: assert property (@(posedge sys_clk) disable iff (srst)
                $rose(enter_req[c]) |-> $past(cnt_q[c]) >= $past(cur_q[c])
                    && $past(cur_q[c]) != 32'h0)
                else $error("entry requested before the setting elapsed");
            a_restart: assert property (@(posedge sys_clk) disable iff (srst)
                cmd_done |=> cnt_q[c] == 32'h0 && !enter_req[c])
                else $error("counter not restarted at completion");
            a_stopped: assert property (@(posedge sys_clk) disable iff (srst)
                !run_w[c] |=> cnt_q[c] == 32'h0 && !enter_req[c])
                else $error("timer running while disabled");
            a_sat: assert property (@(posedge sys_clk) disable iff (srst)
                cnt_q[c] == TIMER_SAT && run_w[c] && !cmd_done |=> cnt_q[c] == TIMER_SAT)
                else $error("counter wrapped past all ones");
            a_unsup: assert property (@(posedge sys_clk) disable iff (srst)
                !caps_q[c].supported |-> flags_w[c][6:3] == 4'h0)
                else $error("dependent flags set on unsupported condition");
            a_saved_en: assert property (@(posedge sys_clk) disable iff (srst)
                save_w && cmd_cond == 2'(c) |=> saved_en_q[c] == ($past(tval_q) != 32'h0))
                else $error("saved timer enabled flag wrong after save");
        end
    endgenerate

    // read data selection
    always_comb begin
        rd_mux = 32'h0;
        if (addr_q[7:6] != SLOT_OWN) begin
            case (addr_q[5:0])
                IDX_FLAGS: rd_mux = {24'h0, flags_w[addr_q[7:6]]};
                IDX_CURRENT: rd_mux = cur_view[addr_q[7:6]];
                IDX_DEFAULT, IDX_SAVED, IDX_RECOVERY, IDX_LOWER, IDX_UPPER: begin
                    rd_mux = caps_q[addr_q[7:6]].supported ? mem_rdata : 32'h0;
                end
                default: rd_mux = 32'h0;
            endcase
        end else if (addr_q[7:5] == PROG_PAGE) begin
            rd_mux = mem_rdata;
        end else begin
            case (addr_q)
                IDX_CTRL: rd_mux = {30'h0, prog_q, epc_q};
                IDX_TVAL: rd_mux = tval_q;
                IDX_STATUS: rd_mux = {23'h0, reject_q, 5'h0, enter_req};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_readdata <= 32'h0;
        end else if (state_q == ST_RD) begin
            avs_readdata <= rd_mux;
        end
    end

    a_low: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_CHK && lower_q != 32'h0 && tval_q < lower_q |=> !ok_q)
        else $error("value below lower bound accepted");
    a_high: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_CHK && mem_rdata != 32'h0 && tval_q > mem_rdata |=> !ok_q)
        else $error("value above upper bound accepted");
    a_rej_off: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_CHK && !epc_q |=> !ok_q)
        else $error("set-timer accepted with epc off");
    a_unsup_rd: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_RD && addr_q[7:6] != SLOT_OWN && addr_q[5:0] == IDX_DEFAULT
            && !caps_q[addr_q[7:6]].supported |=> avs_readdata == 32'h0)
        else $error("factory timer readable while unsupported");
    a_flags_rd: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_RD && addr_q == {2'h1, IDX_FLAGS}
            |=> avs_readdata[FLG_SUPPORTED] == caps_q[1].supported)
        else $error("second slot flags misplaced");
    a_ack_one: assert property (@(posedge sys_clk) disable iff (srst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
endmodule // power_condition_timer
`default_nettype wire

// ### verification/avalon_host_model.sv
// avalon-mm host model for the descriptor block register bus
`timescale 1ns/1ps
`default_nettype none
module avalon_host_model import pct_pkg::*; (
    // clock
    input wire logic sys_clk,
    // avalon-mm master
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
    end

    // request held until waitrequest is sampled low; one idle edge after
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        // only the bench watchdog ends a wait that never gets an answer
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released data shows no stale value
        avs_writedata <= ~d;
        @(posedge sys_clk);
    endtask
endmodule // avalon_host_model
`default_nettype wire

// ### verification/tb_power_condition_timer.sv
// self-checking bench for the power condition timer descriptor block
`timescale 1ns/1ps
`default_nettype none
module tb_power_condition_timer import pct_pkg::*;;
    localparam int TICK = 4;
    logic sys_clk;
    logic srst;
    logic cmd_done;
    cond_caps_t [NUM_COND-1:0] cond_caps;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [NUM_COND-1:0] enter_req;
    int errors;
    int checked;
    int unsigned mem[3][5];
    int unsigned tval_m[3];
    bit epc;
    bit cur_en[3];
    bit saved_en[3];

    power_condition_timer #(.TICK_CYCLES_P(TICK)) power_condition_timer_i (
        .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cond_caps(cond_caps), .cmd_done(cmd_done), .enter_req(enter_req));

    avalon_host_model host_i (
        .sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        host_i.xfer(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        host_i.xfer(1'b0, idx, 32'h0, q);
        check(q, exp);
    endtask

    function automatic logic [31:0] flags_exp(input int c);
        logic [3:0] k;
        k = cond_caps[c];
        if (!k[3]) return 32'h0;
        return {24'h0, 1'b1, k[2:0], saved_en[c], epc & cur_en[c], 2'b00};
    endfunction

    task automatic chk_desc(input int c);
        logic [31:0] s;
        s = cond_caps[c].supported ? 32'hffff_ffff : 32'h0;
        rdc({2'(c), IDX_FLAGS}, flags_exp(c));
        rdc({2'(c), IDX_DEFAULT}, mem[c][0] & s);
        rdc({2'(c), IDX_SAVED}, mem[c][1] & s);
        rdc({2'(c), IDX_RECOVERY}, mem[c][2] & s);
        rdc({2'(c), IDX_LOWER}, mem[c][3] & s);
        rdc({2'(c), IDX_UPPER}, mem[c][4] & s);
        rdc({2'(c), IDX_CURRENT}, (epc && cur_en[c]) ? tval_m[c] & s : 32'h0);
    endtask

    // set-timer request, model decides acceptance from bounds and caps
    task automatic tcmd(input int c, input bit en, input bit sv, input int unsigned v);
        logic [31:0] q;
        bit ok;
        ok = c < 3 && epc;
        if (ok) ok = cond_caps[c].supported && cond_caps[c].changeable;
        if (ok) ok = (mem[c][3] == 0 || v >= mem[c][3]) && (mem[c][4] == 0 || v <= mem[c][4]);
        if (ok) begin
            cur_en[c] = en;
            tval_m[c] = v;
            // an unsavable condition still takes the new setting, unsaved
            if (sv && cond_caps[c].savable) begin
                mem[c][1] = v;
                saved_en[c] = v != 0;
            end
        end
        wr(IDX_TVAL, v);
        wr(IDX_TCMD, {26'h0, sv, en, 2'h0, 2'(c)});
        host_i.xfer(1'b0, IDX_STATUS, 32'h0, q);
        check({31'h0, q[STAT_REJECT]}, {31'h0, !ok});
    endtask

    task automatic pulse();
        cmd_done <= 1'b1;
        @(posedge sys_clk);
        cmd_done <= 1'b0;
    endtask

    task automatic do_reset(input int n);
        srst <= 1'b1;
        repeat (n) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        epc = 0;
        foreach (cur_en[i]) begin
            cur_en[i] = 0;
            saved_en[i] = 0;
            tval_m[i] = 0;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        close_out();
    end

    initial begin
        int unsigned v;
        int n;
        srst = 1'b1;
        cmd_done = 1'b0;
        cond_caps = '0;
        v = $urandom(32'h833b);
        do_reset(20);
        // flags from random straps, epc off and on
        for (int i = 0; i < 4; i++) begin
            cond_caps <= 12'($urandom);
            epc = i[0];
            wr(IDX_CTRL, {31'h0, epc});
            for (int c = 0; c < 3; c++) begin
                rdc({2'(c), IDX_FLAGS}, flags_exp(c));
            end
        end
        $display("test 1 done");
        cond_caps <= {4'h7, 4'ha, 4'hf};
        wr(IDX_CTRL, 32'h2);
        for (int c = 0; c < 3; c++) begin
            for (int w = 0; w < 5; w++) begin
                mem[c][w] = $urandom;
                if (c < 2 && w > 2) mem[c][w] = c ? 0 : w * 30 - 80;
                if (c == 0 && w == 0) mem[c][w] = TIMER_SAT;
                wr({PROG_PAGE, 2'(c), 3'(w)}, mem[c][w]);
            end
        end
        wr(IDX_CTRL, 32'h0);
        epc = 0;
        // locked window and read-only fields ignore writes
        wr({PROG_PAGE, 5'h0}, 32'h1234_5678);
        wr({2'h0, IDX_LOWER}, 32'h5a5a_5a5a);
        for (int c = 0; c < 3; c++) chk_desc(c);
        rdc({2'h0, 6'h02}, 32'h0);
        rdc(8'hd0, 32'h0);
        rdc({PROG_PAGE, 5'h0}, mem[0][0]);
        $display("test 2 done");
        tcmd(0, 1, 0, 32);
        wr(IDX_CTRL, 32'h1);
        epc = 1;
        tcmd(0, 1, 0, 9);
        tcmd(0, 1, 0, 41);
        tcmd(2, 1, 0, 5);
        tcmd(3, 1, 0, 5);
        tcmd(1, 1, 0, TIMER_SAT);
        chk_desc(1);
        tcmd(1, 1, 1, 7);
        chk_desc(1);
        v = $urandom_range(20, 10);
        tcmd(0, 1, 1, v);
        chk_desc(0);
        $display("test 3 done");
        tcmd(1, 1, 0, 3);
        pulse();
        repeat (v * TICK) @(negedge sys_clk);
        check({31'h0, enter_req[0]}, 32'h0);
        n = 0;
        while (enter_req[0] !== 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        check({31'h0, enter_req[0]}, 32'h1);
        @(posedge sys_clk);
        pulse();
        repeat (2) @(negedge sys_clk);
        check({31'h0, enter_req[0]}, 32'h0);
        @(posedge sys_clk);
        $display("test 4 done");
        tcmd(0, 0, 0, v);
        chk_desc(0);
        pulse();
        repeat (v * TICK + 10) @(negedge sys_clk);
        check({31'h0, enter_req[0]}, 32'h0);
        @(posedge sys_clk);
        wr(IDX_CTRL, 32'h0);
        epc = 0;
        chk_desc(1);
        $display("test 5 done");
        do_reset(3);
        for (int c = 0; c < 3; c++) chk_desc(c);
        $display("test 6 done");
        close_out();
    end
endmodule // tb_power_condition_timer
`default_nettype wire
